// [lsdr_pkg.sv]
`default_nettype none
package lsdr_pkg;

  // register offsets
  localparam logic [7:0] OFS_RAM_LAST   = 8'h1F;
  localparam logic [7:0] OFS_STRING_REF = 8'h20;
  localparam logic [7:0] OFS_BOOST_REF  = 8'h21;
  localparam logic [7:0] OFS_OPT_CTRL   = 8'h40;
  localparam logic [7:0] OFS_IMG_LAST   = 8'h51;
  localparam logic [7:0] OFS_NV_PTR     = 8'h60;
  localparam logic [7:0] OFS_NV_CTRL    = 8'h61;
  localparam int         IMG_DEPTH      = int'(OFS_IMG_LAST) + 1;

  // values after reset
  localparam logic [7:0] RST_RAM        = 8'h00;
  localparam logic [7:0] RST_STRING_REF = 8'h64;
  localparam logic [7:0] RST_BOOST_REF  = 8'h64;
  localparam logic [7:0] RST_OPT_CTRL   = 8'hE5;
  localparam logic [6:0] RST_NV_PTR     = 7'h00;
  localparam logic [2:0] RST_NV_CTRL    = 3'h0;

  // field positions
  localparam int DRAIN_THR_LSB = 0;
  localparam int DRAIN_THR_W   = 4;
  localparam int CMD_LSB       = 0;
  localparam int CMD_W         = 3;
  localparam int NV_PTR_W      = 7;

  // transfer commands
  localparam logic [2:0] CMD_OFF = 3'h0;
  localparam logic [2:0] CMD_RD1 = 3'h1;
  localparam logic [2:0] CMD_RD8 = 3'h2;
  localparam logic [2:0] CMD_WR1 = 3'h3;
  localparam logic [2:0] CMD_WR8 = 3'h4;
  localparam logic [2:0] PAGE_LAST = 3'h7;

  typedef struct packed {
    logic       addr_stb;
    logic       wr_stb;
    logic       rd_ack;
    logic [7:0] data;
  } lsdr_hbus_t;

  typedef struct packed {
    logic [7:0]             string_ref;
    logic [7:0]             boost_ref;
    logic [DRAIN_THR_W-1:0] drain_threshold_code;
  } lsdr_ctrl_t;

  function automatic logic [7:0] lsdr_default_byte(input logic [6:0] a);
    if ({1'b0, a} == OFS_STRING_REF) return RST_STRING_REF;
    else if ({1'b0, a} == OFS_BOOST_REF) return RST_BOOST_REF;
    else if ({1'b0, a} == OFS_OPT_CTRL) return RST_OPT_CTRL;
    else return RST_RAM;
  endfunction

endpackage
`default_nettype wire

// [lsdr_nvmem.sv]
`timescale 1ns/1ps
`default_nettype none
module lsdr_nvmem (
  input  wire logic       clk_i,
  input  wire logic [6:0] rd_addr_i,
  output logic      [7:0] rd_data_o,
  input  wire logic       wr_en_i,
  input  wire logic [6:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i
);
  import lsdr_pkg::*;

  // no reset: contents must survive power-down and enable-low
  logic [7:0] cells [0:IMG_DEPTH-1];

  // factory image equals the documented defaults
  initial begin
    for (int i = 0; i < IMG_DEPTH; i++) begin
      cells[i] = lsdr_default_byte(7'(i));
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i && ({1'b0, wr_addr_i} <= OFS_IMG_LAST)) begin
      cells[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = ({1'b0, rd_addr_i} <= OFS_IMG_LAST) ? cells[rd_addr_i] : 8'h00;

endmodule // lsdr_nvmem
`default_nettype wire

// [lsdr_regbank.sv]
// Contract
// - thirty-two free byte locations at addresses 0x00 to 0x1F, loaded from image.
// - power-up copies the nonvolatile image into registers 0x00 through 0x51.
// - host writes never touch nonvolatile memory; enable low discards them.
// - RAM is refilled from nonvolatile copy at power-up and enable rising.
// - location pointer at 0x60 holds seven bits; bit 7 reads zero.
// - control register 0x61 decodes a three-bit transfer command.
// - reads copy nonvolatile into registers; writes program registers into nonvolatile.
// - command 0x03 programs the register at the pointer into its location.
// - eight-byte transfers use fixed pages aligned to multiples of eight.
// - command 0x04 programs all eight registers of the pointed page; the last page, at 0x50, stops at 0x51.
// - string sense reference at 0x20, 8-bit code, default 0x64.
// - boost sense reference at 0x21, 8-bit code, default 0x64.
// - optimizer control 0x40 low nibble is drain threshold, reset 0xE5.
// - address byte sets the register pointer; each further byte advances it.
`timescale 1ns/1ps
`default_nettype none
module lsdr_regbank (
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic                en_i,
  input  wire lsdr_pkg::lsdr_hbus_t hbus_i,
  output logic               [7:0] rd_data_o,
  output lsdr_pkg::lsdr_ctrl_t     ctrl_o,
  output logic                     busy_o
);
  import lsdr_pkg::*;

  typedef enum logic [1:0] {ST_OFF, ST_LOAD, ST_IDLE, ST_XFER} lsdr_state_t;

  lsdr_state_t           state, next_state;
  logic [7:0]            regs      [0:IMG_DEPTH-1];
  logic [7:0]            next_regs [0:IMG_DEPTH-1];
  logic [7:0]            ptr, next_ptr;
  logic [NV_PTR_W-1:0]   nv_ptr, next_nv_ptr;
  logic [CMD_W-1:0]      cmd, next_cmd;
  logic [6:0]            cnt, next_cnt;
  logic [6:0]            last, next_last;
  logic                  op_wr, next_op_wr;
  logic [7:0]            rd_data, next_rd_data;
  logic                  en_q1, en_s;
  logic                  host_ok;
  logic                  cmd_start;
  logic [6:0]            start_base;
  logic [6:0]            start_last;
  logic [7:0]            nv_rdata;
  logic                  nv_we;

  function automatic logic image_mapped(input logic [7:0] a);
    return (a <= OFS_RAM_LAST) || (a == OFS_STRING_REF) || (a == OFS_BOOST_REF) || (a == OFS_OPT_CTRL);
  endfunction

  function automatic logic cmd_valid(input logic [2:0] c);
    return (c == CMD_RD1) || (c == CMD_RD8) || (c == CMD_WR1) || (c == CMD_WR8);
  endfunction

  // enable pin synchroniser; starts high so power-up loads at once
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_q1 <= 1'b1;
      en_s  <= 1'b1;
    end else begin
      en_q1 <= en_i;
      en_s  <= en_q1;
    end
  end

  lsdr_nvmem u_nvmem (
    .clk_i     (clk_i),
    .rd_addr_i (cnt),
    .rd_data_o (nv_rdata),
    .wr_en_i   (nv_we),
    .wr_addr_i (cnt),
    .wr_data_i (regs[cnt])
  );

  // only the transfer sequencer may program; host writes stay in the registers
  assign nv_we  = (state == ST_XFER) && op_wr;
  assign busy_o = (state != ST_IDLE);

  // host data bytes are not stored while the image is loading or the part is disabled
  assign host_ok = (state == ST_IDLE) || (state == ST_XFER);

  always_comb begin
    start_base = cmd_valid(hbus_i.data[2:0]) && ((hbus_i.data[2:0] == CMD_RD8) || (hbus_i.data[2:0] == CMD_WR8))
               ? {nv_ptr[6:3], 3'b000} : nv_ptr;
    start_last = start_base;
    if ((hbus_i.data[2:0] == CMD_RD8) || (hbus_i.data[2:0] == CMD_WR8)) begin
      start_last = {start_base[6:3], PAGE_LAST};
    end
    if ({1'b0, start_last} > OFS_IMG_LAST) begin
      start_last = OFS_IMG_LAST[6:0];
    end
  end

  assign cmd_start = hbus_i.wr_stb && !hbus_i.addr_stb && (state == ST_IDLE) && (ptr == OFS_NV_CTRL)
                   && cmd_valid(hbus_i.data[2:0]) && ({1'b0, nv_ptr} <= OFS_IMG_LAST);

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    if (image_mapped(a)) return regs[a[6:0]];
    else if (a == OFS_NV_PTR) return {1'b0, nv_ptr};
    else if (a == OFS_NV_CTRL) return {5'h00, cmd};
    else return 8'h00;
  endfunction

  always_comb begin
    next_regs    = regs;
    next_ptr     = ptr;
    next_nv_ptr  = nv_ptr;
    next_cmd     = cmd;
    next_state   = state;
    next_cnt     = cnt;
    next_last    = last;
    next_op_wr   = op_wr;
    next_rd_data = read_byte(ptr);

    // register pointer and host writes
    if (hbus_i.addr_stb) begin
      next_ptr = hbus_i.data;
    end else if (hbus_i.wr_stb) begin
      next_ptr = ptr + 8'h01;
      if (host_ok) begin
        if (image_mapped(ptr)) begin
          next_regs[ptr[6:0]] = hbus_i.data;
        end else if (ptr == OFS_NV_PTR) begin
          next_nv_ptr = hbus_i.data[NV_PTR_W-1:0];
        end else if (ptr == OFS_NV_CTRL) begin
          next_cmd = hbus_i.data[CMD_LSB +: CMD_W];
        end
      end
    end else if (hbus_i.rd_ack) begin
      next_ptr = ptr + 8'h01;
    end

    case (state)
      ST_OFF: begin
        if (en_s) begin
          next_state = ST_LOAD;
          next_cnt   = 7'h00;
        end
      end
      ST_LOAD: begin
        next_regs[cnt] = nv_rdata;
        if (cnt == OFS_IMG_LAST[6:0]) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt + 7'h01;
        end
      end
      ST_IDLE: begin
        if (cmd_start) begin
          next_state = ST_XFER;
          next_cnt   = start_base;
          next_last  = start_last;
          next_op_wr = (hbus_i.data[2:0] == CMD_WR1) || (hbus_i.data[2:0] == CMD_WR8);
        end
      end
      ST_XFER: begin
        // a running copy wins over a host byte to the same location
        if (!op_wr) begin
          next_regs[cnt] = nv_rdata;
        end
        if (cnt == last) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt + 7'h01;
        end
      end
      default: next_state = ST_OFF;
    endcase

    // enable low drops every host change; the image returns on the next rise
    if (!en_s) begin
      next_state  = ST_OFF;
      next_cnt    = 7'h00;
      next_nv_ptr = RST_NV_PTR;
      next_cmd    = RST_NV_CTRL;
      next_ptr    = 8'h00;
      for (int i = 0; i < IMG_DEPTH; i++) begin
        next_regs[i] = lsdr_default_byte(7'(i));
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state   <= ST_LOAD;
      ptr     <= 8'h00;
      nv_ptr  <= RST_NV_PTR;
      cmd     <= RST_NV_CTRL;
      cnt     <= 7'h00;
      last    <= 7'h00;
      op_wr   <= 1'b0;
      rd_data <= 8'h00;
      for (int i = 0; i < IMG_DEPTH; i++) begin
        regs[i] <= lsdr_default_byte(7'(i));
      end
    end else begin
      state   <= next_state;
      ptr     <= next_ptr;
      nv_ptr  <= next_nv_ptr;
      cmd     <= next_cmd;
      cnt     <= next_cnt;
      last    <= next_last;
      op_wr   <= next_op_wr;
      rd_data <= next_rd_data;
      for (int i = 0; i < IMG_DEPTH; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  assign rd_data_o = rd_data;
  assign ctrl_o.string_ref           = regs[OFS_STRING_REF[6:0]];
  assign ctrl_o.boost_ref            = regs[OFS_BOOST_REF[6:0]];
  assign ctrl_o.drain_threshold_code = regs[OFS_OPT_CTRL[6:0]][DRAIN_THR_LSB +: DRAIN_THR_W];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_load_len;
    @(posedge clk_i) disable iff (!resetn_i || !en_s)
    (state == ST_LOAD && cnt == 7'h00) |-> ##81 (state == ST_LOAD) ##1 (state == ST_IDLE);
  endproperty

  a_load_whole_image: assert property (p_load_len)
    else $error("image load did not take exactly one cycle per location");

  a_enable_rise_load: assert property ($rose(en_s) |=> (state == ST_LOAD) && (cnt == 7'h00))
    else $error("enable rise did not restart the image load");

  a_disable_defaults: assert property (!en_s |=> ctrl_o.string_ref == RST_STRING_REF
                                        && ctrl_o.boost_ref == RST_BOOST_REF)
    else $error("references not at default while disabled");

  a_disable_opt_ctrl: assert property (!en_s |=> regs[OFS_OPT_CTRL[6:0]] == RST_OPT_CTRL)
    else $error("optimizer control not at default while disabled");

  a_prog_only_xfer: assert property (nv_we |-> (state == ST_XFER) && op_wr)
    else $error("nonvolatile write outside a programming command");

  a_single_prog: assert property ((cmd_start && hbus_i.data[2:0] == CMD_WR1 && en_s)
                                  |=> nv_we && (cnt == $past(nv_ptr)) ##1 !nv_we)
    else $error("single-byte programming did not write one location once");

  a_page_prog: assert property ((cmd_start && hbus_i.data[2:0] == CMD_WR8 && en_s
                                 && {1'b0, nv_ptr[6:3], 3'b111} <= OFS_IMG_LAST)
                                |=> (nv_we && cnt[2:0] == 3'h0) ##1 nv_we [*7] ##1 !nv_we)
    else $error("page programming did not write eight aligned locations");

  a_unused_cmd_idle: assert property ((hbus_i.wr_stb && !hbus_i.addr_stb && ptr == OFS_NV_CTRL && state == ST_IDLE
                                       && !cmd_valid(hbus_i.data[2:0]) && en_s) |=> state == ST_IDLE)
    else $error("unused transfer code started an operation");

  a_ptr_advance: assert property ((hbus_i.wr_stb && !hbus_i.addr_stb && en_s) |=> ptr == $past(ptr) + 8'h01)
    else $error("register pointer did not advance after a data byte");

  a_ptr_loc_bit7: assert property ((ptr == OFS_NV_PTR) |=> !rd_data_o[7])
    else $error("location pointer bit 7 read as one");

  a_ctrl_upper_zero: assert property ((ptr == OFS_NV_CTRL)
                                      |=> rd_data_o[7:3] == 5'h00)
    else $error("transfer control upper bits read as nonzero");

  a_load_step: assert property ((state == ST_LOAD && cnt != OFS_IMG_LAST[6:0] && en_s)
                                |=> (state == ST_LOAD) && (cnt == $past(cnt) + 7'h01))
    else $error("image load skipped or repeated a location");

  a_load_copies: assert property ((state == ST_LOAD && en_s)
                                  |=> regs[$past(cnt)] == $past(nv_rdata))
    else $error("image load did not copy the nonvolatile byte");

  a_xfer_read_lands: assert property ((state == ST_XFER && !op_wr && en_s)
                                      |=> regs[$past(cnt)] == $past(nv_rdata))
    else $error("read command did not copy the nonvolatile byte");

  a_read_one: assert property ((cmd_start && hbus_i.data[2:0] == CMD_RD1 && en_s)
                               |=> (state == ST_XFER && !op_wr && cnt == $past(nv_ptr))
                               ##1 (state == ST_IDLE))
    else $error("single-byte read did not copy one location once");

  a_page_read: assert property ((cmd_start && hbus_i.data[2:0] == CMD_RD8 && en_s
                                 && {1'b0, nv_ptr[6:3], 3'b111} <= OFS_IMG_LAST)
                                |=> (state == ST_XFER && cnt[2:0] == 3'h0 && !op_wr)
                                ##1 (state == ST_XFER) [*7] ##1 (state == ST_IDLE))
    else $error("page read did not copy eight aligned locations");

  a_host_write_lands: assert property ((hbus_i.wr_stb && !hbus_i.addr_stb && state == ST_IDLE
                                        && image_mapped(ptr) && en_s)
                                       |=> regs[$past(ptr[6:0])] == $past(hbus_i.data))
    else $error("host byte did not land in the addressed register");

  a_nv_ptr_write: assert property ((hbus_i.wr_stb && !hbus_i.addr_stb && host_ok
                                    && ptr == OFS_NV_PTR && en_s)
                                   |=> nv_ptr == $past(hbus_i.data[6:0]))
    else $error("location pointer did not take the host byte");

  a_cmd_write: assert property ((hbus_i.wr_stb && !hbus_i.addr_stb && host_ok
                                 && ptr == OFS_NV_CTRL && en_s)
                                |=> cmd == $past(hbus_i.data[2:0]))
    else $error("transfer control did not take the host code");

  a_ptr_past_image: assert property ((hbus_i.wr_stb && !hbus_i.addr_stb && state == ST_IDLE
                                      && ptr == OFS_NV_CTRL && cmd_valid(hbus_i.data[2:0])
                                      && {1'b0, nv_ptr} > OFS_IMG_LAST && en_s)
                                     |=> state == ST_IDLE)
    else $error("command started with pointer beyond the image");

  a_addr_sets_ptr: assert property ((hbus_i.addr_stb && en_s)
                                    |=> ptr == $past(hbus_i.data))
    else $error("address byte did not set the register pointer");

  a_rdack_advance: assert property ((hbus_i.rd_ack && !hbus_i.wr_stb && !hbus_i.addr_stb && en_s)
                                    |=> ptr == $past(ptr) + 8'h01)
    else $error("register pointer did not advance after a read byte");

  a_disable_clears: assert property (!en_s
                                     |=> (state == ST_OFF) && (cmd == RST_NV_CTRL)
                                         && (nv_ptr == RST_NV_PTR))
    else $error("disable did not drop transfer state");

  c_load_done:  cover property ((state == ST_LOAD) ##1 (state == ST_IDLE));
  c_page_write: cover property (cmd_start && hbus_i.data[2:0] == CMD_WR8);
  c_byte_read:  cover property (cmd_start && hbus_i.data[2:0] == CMD_RD1);
  c_page_read:  cover property (cmd_start && hbus_i.data[2:0] == CMD_RD8);
  c_enable_cyc: cover property ($fell(en_s) ##[1:20] $rose(en_s));

endmodule // lsdr_regbank
`default_nettype wire

// [lsdr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lsdr_host_model #(
  parameter int PROG_WAIT = 50000
) (
  input  wire logic                 clk_i,
  input  wire logic           [7:0] rd_data_i,
  output var  lsdr_pkg::lsdr_hbus_t hbus_o
);
  import lsdr_pkg::*;

  initial hbus_o = '0;

  // one strobe, then a quiet cycle with scrambled data so stale bytes never match
  task automatic strobe(input logic [2:0] k, input logic [7:0] d);
    @(negedge clk_i);
    hbus_o = '{addr_stb: k[2], wr_stb: k[1], rd_ack: k[0], data: d};
    @(negedge clk_i);
    hbus_o = '{addr_stb: 1'b0, wr_stb: 1'b0, rd_ack: 1'b0, data: ~d};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    strobe(3'b100, a);
    strobe(3'b010, d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    strobe(3'b100, a);
    @(negedge clk_i);
    d = rd_data_i;
  endtask

  task automatic rd_next(output logic [7:0] d);
    strobe(3'b001, 8'h00);
    @(negedge clk_i);
    d = rd_data_i;
  endtask

  // the command is held the whole wait, then always cleared
  task automatic nv_cmd(input logic [6:0] p, input logic [2:0] c, input int hold);
    wr(OFS_NV_PTR, {1'b0, p});
    wr(OFS_NV_CTRL, {5'h00, c});
    // programming commands always wait the full programming time
    repeat ((c >= CMD_WR1) ? PROG_WAIT : hold) @(negedge clk_i);
    wr(OFS_NV_CTRL, 8'h00);
  endtask
endmodule // lsdr_host_model
`default_nettype wire

// [led_driver_regs_eeprom_shadow_test.sv]
`timescale 1ns/1ps
`default_nettype none
module led_driver_regs_eeprom_shadow_test;
  import lsdr_pkg::*;
  localparam int PROG = 40;
  logic       clk_i;
  logic       resetn_i;
  logic       en_i;
  lsdr_hbus_t hbus;
  logic [7:0] rd_data;
  lsdr_ctrl_t ctrl;
  logic       busy;
  int         fail_count;
  int         n_tests;
  int         m[128];
  int         nv[128];
  logic [7:0] v;

  lsdr_regbank u_lsdr_regbank (.clk_i(clk_i), .resetn_i(resetn_i), .en_i(en_i), .hbus_i(hbus),
                               .rd_data_o(rd_data), .ctrl_o(ctrl), .busy_o(busy));
  lsdr_host_model #(.PROG_WAIT(PROG)) u_lsdr_host_model (.clk_i(clk_i), .rd_data_i(rd_data), .hbus_o(hbus));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  function automatic bit mapped(input int a);
    return a <= OFS_BOOST_REF || a == OFS_OPT_CTRL || a == OFS_NV_PTR || a == OFS_NV_CTRL;
  endfunction

  function automatic void m_wr(input int a, input int d);
    if (a == OFS_NV_PTR) m[a] = d & 8'h7F;
    else if (a == OFS_NV_CTRL) m[a] = d & 8'h07;
    else if (mapped(a)) m[a] = d & 8'hFF;
  endfunction

  function automatic void m_load();
    for (int a = 0; a <= OFS_IMG_LAST; a++) m[a] = mapped(a) ? nv[a] : 0;
    m[OFS_NV_PTR] = 0;
    m[OFS_NV_CTRL] = 0;
  endfunction

  function automatic void m_exec(input int p, input int c);
    int base;
    int cnt;
    if (c < 1 || c > 4 || p > OFS_IMG_LAST) return;
    base = (c == 2 || c == 4) ? (p & ~7) : p;
    cnt = (c == 2 || c == 4) ? 8 : 1;
    for (int a = base; a < base + cnt && a <= OFS_IMG_LAST; a++) begin
      if (c <= 2 && mapped(a)) m[a] = nv[a];
      else if (c >= 3) nv[a] = m[a];
    end
  endfunction

  task automatic scan(input string t);
    for (int a = 0; a <= OFS_NV_CTRL; a++) begin
      u_lsdr_host_model.rd(8'(a), v);
      check($sformatf("reg %h", a), v, m[a][7:0]);
    end
    check("string_ref", ctrl.string_ref, m[OFS_STRING_REF][7:0]);
    check("boost_ref", ctrl.boost_ref, m[OFS_BOOST_REF][7:0]);
    check("drain_code", {4'h0, ctrl.drain_threshold_code}, m[OFS_OPT_CTRL][7:0] & 8'h0F);
    $display("test %s done", t);
  endtask

  task automatic wait_idle();
    int i;
    repeat (2) @(negedge clk_i);
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk_i);
    if (i == 300) begin
      fail_count++;
      $display("[ERR] busy expected 0 seen %b", busy);
      summarize();
    end
  endtask

  initial begin
    int p;
    int c;
    resetn_i = 1'b0;
    en_i = 1'b1;
    fail_count = 0;
    n_tests = 0;
    for (int a = 0; a < 128; a++) nv[a] = 0;
    nv[OFS_STRING_REF] = RST_STRING_REF;
    nv[OFS_BOOST_REF] = RST_BOOST_REF;
    nv[OFS_OPT_CTRL] = RST_OPT_CTRL;
    m_load();
    void'($urandom(32'hF21A9C4F));
    repeat (20) @(negedge clk_i);
    resetn_i = 1'b1;
    @(negedge clk_i);
    check("busy", {7'h00, busy}, 8'h01);
    wait_idle();
    scan("defaults");
    // one address byte, then a burst that rides on the auto-increment
    u_lsdr_host_model.strobe(3'b100, 8'h00);
    for (int a = 0; a <= OFS_RAM_LAST; a++) begin
      v = 8'($urandom);
      m_wr(a, v);
      u_lsdr_host_model.strobe(3'b010, v);
    end
    u_lsdr_host_model.rd(8'h00, v);
    check("burst 00", v, m[0][7:0]);
    for (int a = 1; a <= OFS_RAM_LAST; a++) begin
      u_lsdr_host_model.rd_next(v);
      check($sformatf("burst %h", a), v, m[a][7:0]);
    end
    for (int k = 0; k < 7; k++) begin
      p = (k == 0) ? OFS_STRING_REF : (k == 1) ? OFS_BOOST_REF : (k == 2) ? OFS_OPT_CTRL :
          (k == 3) ? 8'h30 : (k == 4) ? 8'h7F : (k == 5) ? OFS_NV_PTR : OFS_NV_CTRL;
      v = (k == 6) ? 8'hF8 : 8'($urandom);
      if (k == 2) v = {m[OFS_OPT_CTRL][7:4], v[3:0]};
      m_wr(p, v);
      u_lsdr_host_model.wr(8'(p), v);
    end
    scan("writes");
    // every code exactly twice; a few pointers past the image are refused
    for (int i = 0; i < 16; i++) begin
      c = i % 8;
      p = $urandom_range(0, 8'h57);
      for (int k = 0; k < 8; k++) begin
        v = 8'($urandom);
        m_wr((p & ~7) + k, v);
        u_lsdr_host_model.wr(8'((p & ~7) + k), v);
      end
      u_lsdr_host_model.nv_cmd(7'(p), 3'(c), (c >= 3) ? PROG : 10);
      m_wr(OFS_NV_PTR, p);
      m_exec(p, c);
      wait_idle();
      scan($sformatf("command %0d", c));
    end
    @(negedge clk_i);
    en_i = 1'b0;
    repeat (10) @(negedge clk_i);
    check("busy off", {7'h00, busy}, 8'h01);
    en_i = 1'b1;
    wait_idle();
    m_load();
    scan("reload");
    summarize();
  end
endmodule // led_driver_regs_eeprom_shadow_test
`default_nettype wire
